//--- logic/lf_wake_consts.svh
// Register map, reset values, command codes and timing constants of the wake-up register bank.
// Functional notes
// - Duty-cycle enable uses 1/2/4/8 ms off time.
// - Gain control may act on first burst only.
// - Gain control up-down when set, else down.
// - Optional double pattern match before wake-up.
// - Slicer absolute threshold reference select.
// - Slicer threshold reduction bit.
// - Pattern correlator mismatch tolerance field.
// - Carrier frequency detection strictness field.
// - Hysteresis 40 mV when clear, 20 mV set.
// - Hysteresis both edges or rising only.
// - Slicer time constant code, reset 100.
// - Envelope time constant code, reset 000.
// - Sixteen-bit pattern in two bytes, given defaults.
// - Bit rate code and timeout code fields.
// - Artificial wake pulse lasts 128 us per period.
// - Clear-false command zeroes false wake counter.
// - Six-bit address selects registers 0 to 13.
`ifndef LF_WAKE_CONSTS_SVH
`define LF_WAKE_CONSTS_SVH

`define CFG_COUNT 9
`define ADDR_RSSI 6'h0A
`define ADDR_FALSE 6'h0D

`define DEF_R0 8'h0E
`define DEF_R1 8'h23
`define DEF_R2 8'h00
`define DEF_R3 8'h20
`define DEF_R4 8'h10
`define DEF_R5 8'h69
`define DEF_R6 8'h96
`define DEF_R7 8'h0B
`define DEF_R8 8'h00

`define MASK_R0 8'h3F
`define MASK_R1 8'hF7
`define MASK_R2 8'hE3
`define MASK_R8 8'h07

`define MODE_WRITE 2'h0
`define MODE_READ 2'h1
`define MODE_DIRECT 2'h3

`define DC_CLEAR_WAKE 6'h00
`define DC_RESET_RSSI 6'h01
`define DC_TRIM_OSC 6'h02
`define DC_CLEAR_FALSE 6'h03
`define DC_PRESET 6'h04

`define CLK_MHZ 250
`define MS_TIME_US 1000
`define AW_PULSE_US 128

`define AW_P1_MS 23'h0003E8
`define AW_P2_MS 23'h001388
`define AW_P3_MS 23'h004E20
`define AW_P4_MS 23'h01D4C0
`define AW_P5_MS 23'h0DBBA0
`define AW_P6_MS 23'h36EE80
`define AW_P7_MS 23'h6DDD00

`endif

//--- logic/lf_wake_pkg.sv
// Types shared by the wake-up register bank.
`default_nettype none
package lf_wake_pkg;

  typedef enum logic [2:0] {
    st_idle,
    st_cmd,
    st_wdata,
    st_rdata,
    st_hold
  } sdi_state_e;

endpackage
`default_nettype wire

//--- logic/lf_wake_timers.sv
// Duty-cycle listening and artificial wake-up timers.
`timescale 1ns/10ps
`default_nettype none
`include "lf_wake_consts.svh"
module lf_wake_timers #(
  parameter int MS_CYC = 250000,
  parameter int AW_PULSE_CYC = 32000
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic listen_en_i,
  input wire logic duty_en_i,
  input wire logic [1:0] off_code_i,
  input wire logic [2:0] aw_code_i,
  output logic amp_on_o,
  output logic aw_pulse_o
);

  localparam int DW = $clog2(MS_CYC);
  localparam int PW = $clog2(AW_PULSE_CYC);

  function automatic logic [22:0] aw_period(input logic [2:0] c);
    case (c)
      3'h1: aw_period = `AW_P1_MS;
      3'h2: aw_period = `AW_P2_MS;
      3'h3: aw_period = `AW_P3_MS;
      3'h4: aw_period = `AW_P4_MS;
      3'h5: aw_period = `AW_P5_MS;
      3'h6: aw_period = `AW_P6_MS;
      default: aw_period = `AW_P7_MS;
    endcase
  endfunction

  logic [DW-1:0] ms_div;
  logic [3:0] ms_cnt;
  logic [22:0] aw_cnt;
  logic [PW-1:0] pulse_cnt;

  wire ms_tick = (ms_div == DW'(MS_CYC - 1));
  wire [3:0] off_len = 4'h1 << off_code_i;
  wire duty_flip = amp_on_o | (ms_cnt == off_len - 4'h1);
  wire aw_hit = ms_tick && (aw_cnt == aw_period(aw_code_i) - 23'h000001);
  wire aw_run = run_i && (aw_code_i != 3'h0);
  wire pulse_end = (pulse_cnt == PW'(AW_PULSE_CYC - 1));

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ms_div <= '0;
    end else begin
      ms_div <= ms_tick ? '0 : ms_div + 1'b1;
    end
  end

  // The on phase lasts one tick, the off phase the coded number of ticks.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      amp_on_o <= 1'b0;
      ms_cnt <= 4'h0;
    end else if (!listen_en_i) begin
      amp_on_o <= 1'b0;
      ms_cnt <= 4'h0;
    end else if (!duty_en_i) begin
      amp_on_o <= 1'b1;
      ms_cnt <= 4'h0;
    end else if (ms_tick) begin
      amp_on_o <= duty_flip ? ~amp_on_o : amp_on_o;
      ms_cnt <= duty_flip ? 4'h0 : ms_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_cnt <= 23'h000000;
    end else if (!aw_run) begin
      aw_cnt <= 23'h000000;
    end else if (ms_tick) begin
      aw_cnt <= aw_hit ? 23'h000000 : aw_cnt + 23'h000001;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_pulse_o <= 1'b0;
      pulse_cnt <= '0;
    end else if (aw_run && aw_hit) begin
      aw_pulse_o <= 1'b1;
      pulse_cnt <= '0;
    end else if (aw_pulse_o) begin
      aw_pulse_o <= !pulse_end;
      pulse_cnt <= pulse_cnt + 1'b1;
    end
  end

  a_aw_pulse_len: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $fell(aw_pulse_o) |-> $past(pulse_cnt) == PW'(AW_PULSE_CYC - 1))
    else $error("artificial wake pulse has the wrong length");

  a_aw_disabled: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(aw_pulse_o) |-> $past(aw_code_i) != 3'h0 && $past(run_i))
    else $error("artificial wake raised while disabled");

  a_duty_static: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    listen_en_i && !duty_en_i |=> amp_on_o)
    else $error("channel not on in continuous listening");

endmodule // lf_wake_timers
`default_nettype wire

//--- logic/lf_wakeup_config_registers.sv
// Register bank of the wake-up receiver behind its four-wire serial port.
`timescale 1ns/10ps
`default_nettype none
`include "lf_wake_consts.svh"
module lf_wakeup_config_registers #(
  parameter int MS_CYC = `MS_TIME_US * `CLK_MHZ,
  parameter int AW_PULSE_CYC = `AW_PULSE_US * `CLK_MHZ
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic cs_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  input wire logic [4:0] signal_strength_value_i,
  input wire logic false_wake_i,
  output logic power_down_o,
  output logic channel_enable_o,
  output logic duty_cycle_enable_o,
  output logic slicer_absolute_ref_o,
  output logic gain_first_burst_only_o,
  output logic gain_bidirectional_o,
  output logic antenna_damper_enable_o,
  output logic double_pattern_enable_o,
  output logic correlator_enable_o,
  output logic osc_enable_o,
  output logic slicer_threshold_reduce_o,
  output logic [1:0] pattern_tolerance_o,
  output logic [1:0] frequency_tolerance_o,
  output logic small_hysteresis_select_o,
  output logic rising_only_hysteresis_o,
  output logic [2:0] slicer_time_constant_o,
  output logic [2:0] envelope_time_constant_o,
  output logic [1:0] damping_resistor_select_o,
  output logic [3:0] gain_reduction_o,
  output logic [15:0] wake_pattern_o,
  output logic [2:0] timeout_code_o,
  output logic [4:0] bit_rate_code_o,
  output logic amp_on_o,
  output logic artificial_wake_o,
  output logic clear_wake_o,
  output logic reset_rssi_o,
  output logic trim_osc_o
);

  localparam logic [7:0] CFG_DEF [0:`CFG_COUNT-1] = '{
    `DEF_R0, `DEF_R1, `DEF_R2, `DEF_R3, `DEF_R4,
    `DEF_R5, `DEF_R6, `DEF_R7, `DEF_R8
  };

  localparam logic [7:0] CFG_MASK [0:`CFG_COUNT-1] = '{
    `MASK_R0, `MASK_R1, `MASK_R2, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, `MASK_R8
  };

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and serial clock edge.

  logic cs_m;
  logic cs_s;
  logic sclk_m;
  logic sclk_s;
  logic sclk_d;
  logic sdi_m;
  logic sdi_s;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_m <= 1'b0;
      cs_s <= 1'b0;
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      sdi_m <= 1'b0;
      sdi_s <= 1'b0;
    end else begin
      cs_m <= cs_i;
      cs_s <= cs_m;
      sclk_m <= sclk_i;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      sdi_m <= sdi_i;
      sdi_s <= sdi_m;
    end
  end

  // Data and clock share the same delay, so sampling at the seen falling
  // edge matches what the host meant; the host must keep its minimum timing.
  wire fall = sclk_d & ~sclk_s;

  //////////////////////////////////////////////////////////////////////////////
  // Serial command decoder.

  lf_wake_pkg::sdi_state_e state;
  lf_wake_pkg::sdi_state_e next_state;
  logic [2:0] bit_cnt;
  logic [6:0] shift;
  logic [5:0] addr;
  logic [7:0] cfg [0:`CFG_COUNT-1];
  logic [7:0] sdo_sh;
  logic [7:0] false_wake_count;
  logic [4:0] signal_strength;

  wire byte_done = fall && (bit_cnt == 3'h7);
  wire [7:0] in_byte = {shift, sdi_s};
  wire [1:0] cmd_mode = in_byte[7:6];
  wire [5:0] cmd_addr = in_byte[5:0];
  wire in_cmd = (state == lf_wake_pkg::st_cmd);
  wire cmd_done = in_cmd && byte_done;
  wire is_read = cmd_done && (cmd_mode == `MODE_READ);
  wire is_direct = cmd_done && (cmd_mode == `MODE_DIRECT);
  wire wr_stb = byte_done && (state == lf_wake_pkg::st_wdata);
  wire rd_next = byte_done && (state == lf_wake_pkg::st_rdata);
  wire [5:0] inc_addr = addr + 6'h01;
  wire [5:0] rd_addr = in_cmd ? cmd_addr : inc_addr;

  wire preset_stb = is_direct && (cmd_addr == `DC_PRESET);
  wire clr_false = is_direct && (cmd_addr == `DC_CLEAR_FALSE);

  // Only the nine stored registers take writes; the rest are read-only.
  wire wr_hit = wr_stb && (addr < 6'(`CFG_COUNT));
  wire [3:0] wr_idx = addr[3:0];
  wire [7:0] wr_mask = CFG_MASK[wr_idx];
  wire [7:0] wr_merged = (cfg[wr_idx] & ~wr_mask) | (in_byte & wr_mask);

  // Register 9 and the unused registers read as zero.
  wire rd_cfg = rd_addr < 6'(`CFG_COUNT);
  wire rd_rssi = rd_addr == `ADDR_RSSI;
  wire rd_fw = rd_addr == `ADDR_FALSE;
  wire [7:0] rd_byte = rd_cfg ? cfg[rd_addr[3:0]] :
                       rd_rssi ? {3'h0, signal_strength} :
                       rd_fw ? false_wake_count : 8'h00;

  always_comb begin
    next_state = state;
    unique case (state)
      lf_wake_pkg::st_idle: begin
        if (cs_s) begin
          next_state = lf_wake_pkg::st_cmd;
        end
      end
      lf_wake_pkg::st_cmd: begin
        if (byte_done) begin
          if (cmd_mode == `MODE_WRITE) begin
            next_state = lf_wake_pkg::st_wdata;
          end else if (cmd_mode == `MODE_READ) begin
            next_state = lf_wake_pkg::st_rdata;
          end else begin
            next_state = lf_wake_pkg::st_hold;
          end
        end
      end
      lf_wake_pkg::st_wdata,
      lf_wake_pkg::st_rdata,
      lf_wake_pkg::st_hold: begin
        next_state = state;
      end
    endcase
    if (!cs_s) begin
      next_state = lf_wake_pkg::st_idle;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= lf_wake_pkg::st_idle;
      bit_cnt <= 3'h0;
      shift <= 7'h00;
    end else begin
      state <= next_state;
      bit_cnt <= (!cs_s) ? 3'h0 : (fall ? bit_cnt + 3'h1 : bit_cnt);
      shift <= fall ? in_byte[6:0] : shift;
    end
  end

  // Consecutive bytes in one frame go to the following address.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr <= 6'h00;
    end else if (cmd_done) begin
      addr <= cmd_addr;
    end else if (wr_stb || rd_next) begin
      addr <= inc_addr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data shifter.

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sdo_sh <= 8'h00;
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
    end else begin
      sdo_oe_o <= cs_s;
      if (is_read || rd_next) begin
        sdo_sh <= {rd_byte[6:0], 1'b0};
        sdo_o <= rd_byte[7];
      end else if (fall && state == lf_wake_pkg::st_rdata) begin
        sdo_sh <= {sdo_sh[6:0], 1'b0};
        sdo_o <= sdo_sh[7];
      end else if (!cs_s) begin
        sdo_o <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration storage.

  // A restore of defaults reloads all nine registers with their reset values,
  // which leave the two reserved bits of register 0 clear.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < `CFG_COUNT; i++) begin
        cfg[i] <= CFG_DEF[i];
      end
    end else if (preset_stb) begin
      for (int i = 0; i < `CFG_COUNT; i++) begin
        cfg[i] <= CFG_DEF[i];
      end
    end else if (wr_hit) begin
      cfg[wr_idx] <= wr_merged;
    end
  end

  // An event in the same cycle as a clear is counted after the clear.
  wire fw_inc = false_wake_i && (false_wake_count != 8'hFF);
  wire [7:0] next_fw = clr_false ? {7'h00, false_wake_i} :
                       (fw_inc ? false_wake_count + 8'h01 : false_wake_count);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      false_wake_count <= 8'h00;
      signal_strength <= 5'h00;
    end else begin
      false_wake_count <= next_fw;
      signal_strength <= signal_strength_value_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clear_wake_o <= 1'b0;
      reset_rssi_o <= 1'b0;
      trim_osc_o <= 1'b0;
    end else begin
      clear_wake_o <= is_direct && (cmd_addr == `DC_CLEAR_WAKE);
      reset_rssi_o <= is_direct && (cmd_addr == `DC_RESET_RSSI);
      trim_osc_o <= is_direct && (cmd_addr == `DC_TRIM_OSC);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Field outputs.

  assign duty_cycle_enable_o = cfg[0][5];
  assign channel_enable_o = cfg[0][1];
  assign power_down_o = cfg[0][0];
  assign slicer_absolute_ref_o = cfg[1][7];
  assign gain_first_burst_only_o = cfg[1][6];
  assign gain_bidirectional_o = cfg[1][5];
  assign antenna_damper_enable_o = cfg[1][4];
  assign double_pattern_enable_o = cfg[1][2];
  assign correlator_enable_o = cfg[1][1];
  assign osc_enable_o = cfg[1][0];
  assign slicer_threshold_reduce_o = cfg[2][7];
  assign pattern_tolerance_o = cfg[2][6:5];
  assign frequency_tolerance_o = cfg[2][1:0];
  assign small_hysteresis_select_o = cfg[3][7];
  assign rising_only_hysteresis_o = cfg[3][6];
  assign slicer_time_constant_o = cfg[3][5:3];
  assign envelope_time_constant_o = cfg[3][2:0];
  assign damping_resistor_select_o = cfg[4][5:4];
  assign gain_reduction_o = cfg[4][3:0];
  assign wake_pattern_o = {cfg[6], cfg[5]};
  assign timeout_code_o = cfg[7][7:5];
  assign bit_rate_code_o = cfg[7][4:0];

  lf_wake_timers #(
    .MS_CYC(MS_CYC),
    .AW_PULSE_CYC(AW_PULSE_CYC)
  ) u_timers (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .run_i(~cfg[0][0]),
    .listen_en_i(cfg[0][1] & ~cfg[0][0]),
    .duty_en_i(cfg[0][5]),
    .off_code_i(cfg[4][7:6]),
    .aw_code_i(cfg[8][2:0]),
    .amp_on_o(amp_on_o),
    .aw_pulse_o(artificial_wake_o)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_agc_fields: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_stb && addr == 6'h01 |=> {slicer_absolute_ref_o, gain_first_burst_only_o,
      gain_bidirectional_o, double_pattern_enable_o} ==
      {$past(in_byte[7]), $past(in_byte[6]), $past(in_byte[5]), $past(in_byte[2])})
    else $error("control register 1 fields not updated");

  a_tol_fields: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_stb && addr == 6'h02 |=> {slicer_threshold_reduce_o, pattern_tolerance_o,
      frequency_tolerance_o} == {$past(in_byte[7:5]), $past(in_byte[1:0])})
    else $error("tolerance fields not updated");

  a_slicer_fields: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_stb && addr == 6'h03 |=> {small_hysteresis_select_o, rising_only_hysteresis_o,
      slicer_time_constant_o, envelope_time_constant_o} == $past(in_byte))
    else $error("slicer fields not updated");

  a_timing_fields: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_stb && addr == 6'h07 |=> {timeout_code_o, bit_rate_code_o} == $past(in_byte))
    else $error("timing fields not updated");

  a_preset_values: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    preset_stb |=> wake_pattern_o == {`DEF_R6, `DEF_R5} && channel_enable_o &&
      !power_down_o && osc_enable_o && correlator_enable_o && gain_bidirectional_o)
    else $error("defaults not restored");

  a_clear_false: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    clr_false && !false_wake_i |=> false_wake_count == 8'h00)
    else $error("false wake counter not cleared");

  a_ro_counter: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_stb && addr == `ADDR_FALSE && !false_wake_i |=> $stable(false_wake_count))
    else $error("write changed the read-only counter");

  a_read_first_bit: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    is_read && cmd_addr == 6'h06 |=> sdo_o == cfg[6][7] ##1 sdo_oe_o)
    else $error("read data not presented on the serial output");

  a_sdo_release: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !cs_s |=> !sdo_oe_o && !sdo_o)
    else $error("serial output still driven after deselect");

  a_fw_count: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    false_wake_i && !clr_false && false_wake_count != 8'hFF |=>
      false_wake_count == $past(false_wake_count) + 8'h01)
    else $error("false wake counter did not advance");

  a_rsvd_agc_bit: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_stb && addr == 6'h01 |=> !cfg[1][3])
    else $error("reserved control bit took a write");

  a_rsvd_tol_bits: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_stb && addr == 6'h02 |=> cfg[2][4:2] == 3'h0)
    else $error("reserved tolerance bits took a write");

endmodule // lf_wakeup_config_registers
`default_nettype wire

//--- sim/lf_host_model.sv
// Microcontroller model that drives the four-wire serial port of the register bank.
`timescale 1ns/10ps
`default_nettype none
module lf_host_model (
  input wire logic clk_sys_i,
  input wire logic sdo_i,
  output logic cs_o,
  output logic sclk_o,
  output logic sdi_o,
  output logic [7:0] rd_byte_o,
  output logic rd_stb_o
);
  localparam int HALF = 6;
  initial begin
    cs_o = 1'b0;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
    rd_byte_o = 8'h00;
    rd_stb_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Sdo is taken on the rising sclk edge, long after the device has moved it.
  task automatic shift_byte(input logic [7:0] tx, input logic rd);
    for (int i = 7; i >= 0; i--) begin
      sdi_o <= tx[i];
      sclk_o <= 1'b1;
      if (rd) rd_byte_o <= {rd_byte_o[6:0], sdo_i};
      repeat (HALF) @(posedge clk_sys_i);
      sclk_o <= 1'b0;
      repeat (HALF) @(posedge clk_sys_i);
    end
    rd_stb_o <= rd;
    @(posedge clk_sys_i);
    rd_stb_o <= 1'b0;
  endtask
  task automatic begin_frame(input logic [1:0] mode, input logic [5:0] adr);
    cs_o <= 1'b1;
    repeat (HALF) @(posedge clk_sys_i);
    shift_byte({mode, adr}, 1'b0);
  endtask
  // Released lines fall to their pull-down level.
  task automatic end_frame();
    repeat (HALF) @(posedge clk_sys_i);
    cs_o <= 1'b0;
    sdi_o <= 1'b0;
    repeat (2 * HALF) @(posedge clk_sys_i);
  endtask
endmodule // lf_host_model
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the wake-up register bank.
`timescale 1ns/10ps
`default_nettype none
`include "lf_wake_consts.svh"
module tb;
  localparam int MS = 20;
  localparam int AWP = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] rssi = 5'h00;
  logic fw = 1'b0;
  logic sel_aw = 1'b0;
  integer seed = 32'hBFF6BD0F;
  wire logic cs, sclk, sdi, sdo, sdo_oe, rd_stb, pd, ch, duty, sar, gfb, gbd, dmp, dbl, cor;
  wire logic osc, str, shs, roh, amp, aw, cwk, rrs, tro;
  wire logic [1:0] ptl, ftl, drs;
  wire logic [2:0] stc, etc, tmo;
  wire logic [3:0] grd;
  wire logic [4:0] brc;
  wire logic [7:0] rd_byte;
  wire logic [15:0] pat;
  wire logic [2:0] dcp = {tro, rrs, cwk};
  wire logic mon = sel_aw ? aw : amp;
  logic [7:0] img [0:13];
  logic [7:0] exp_q[$];
  logic [7:0] wq[$];
  int error_cnt = 0;
  int check_count = 0;
  int fcnt = 0;
  int n;
  int pul [3] = '{0, 0, 0};
  always #2 clk = ~clk;
  // The serial output has no pull, so a released line shows the inverse to expose late sampling.
  lf_host_model host (.clk_sys_i(clk), .sdo_i(sdo_oe ? sdo : ~sdo), .cs_o(cs), .sclk_o(sclk),
    .sdi_o(sdi), .rd_byte_o(rd_byte), .rd_stb_o(rd_stb));
  lf_wakeup_config_registers #(.MS_CYC(MS), .AW_PULSE_CYC(AWP)) dut (.clk_sys_i(clk),
    .rst_n_i(rst_n), .cs_i(cs), .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .signal_strength_value_i(rssi), .false_wake_i(fw), .power_down_o(pd),
    .channel_enable_o(ch), .duty_cycle_enable_o(duty), .slicer_absolute_ref_o(sar),
    .gain_first_burst_only_o(gfb), .gain_bidirectional_o(gbd), .antenna_damper_enable_o(dmp),
    .double_pattern_enable_o(dbl), .correlator_enable_o(cor), .osc_enable_o(osc),
    .slicer_threshold_reduce_o(str), .pattern_tolerance_o(ptl), .frequency_tolerance_o(ftl),
    .small_hysteresis_select_o(shs), .rising_only_hysteresis_o(roh),
    .slicer_time_constant_o(stc), .envelope_time_constant_o(etc),
    .damping_resistor_select_o(drs), .gain_reduction_o(grd), .wake_pattern_o(pat),
    .timeout_code_o(tmo), .bit_rate_code_o(brc), .amp_on_o(amp), .artificial_wake_o(aw),
    .clear_wake_o(cwk), .reset_rssi_o(rrs), .trim_osc_o(tro));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      error_cnt++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [7:0] mask(input int i);
    case (i)
      0: return `MASK_R0;
      1: return `MASK_R1;
      2: return `MASK_R2;
      8: return `MASK_R8;
      default: return (i < 9) ? 8'hFF : 8'h00;
    endcase
  endfunction
  task automatic defaults();
    img = '{`DEF_R0, `DEF_R1, `DEF_R2, `DEF_R3, `DEF_R4, `DEF_R5, `DEF_R6, `DEF_R7, `DEF_R8,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  endtask
  // Reserved and read-only bits keep their old value in the image.
  task automatic put(input int i, input logic [7:0] v);
    wq.push_back(v);
    if (i < 9) img[i] = (v & mask(i)) | (img[i] & ~mask(i));
  endtask
  task automatic wr(input logic [5:0] adr);
    host.begin_frame(`MODE_WRITE, adr);
    while (wq.size() > 0) host.shift_byte(wq.pop_front(), 1'b0);
    host.end_frame();
  endtask
  task automatic cmd(input logic [1:0] mode, input logic [5:0] c);
    host.begin_frame(mode, c);
    if (mode == 2'h2) host.shift_byte(8'hFF, 1'b0);
    host.end_frame();
  endtask
  // Addresses beyond the last register read as zero.
  function automatic logic [7:0] exp_at(input int a);
    if (a == 10) return {3'h0, rssi};
    if (a == 13) return fcnt[7:0];
    return (a < 14) ? img[a] : 8'h00;
  endfunction
  task automatic read_all(input logic [5:0] a0 = 6'h00);
    for (int i = 0; i < 14; i++)
      exp_q.push_back(exp_at((a0 + i) % 64));
    host.begin_frame(`MODE_READ, a0);
    repeat (14) host.shift_byte(8'h00, 1'b1);
    host.end_frame();
    check({sdo_oe, sdo}, 2'b00);
  endtask
  task automatic check_ports();
    check({duty, ch, pd}, {img[0][5], img[0][1:0]});
    check({sar, gfb, gbd, dmp, 1'b0, dbl, cor, osc}, img[1]);
    check({str, ptl, 3'h0, ftl}, img[2]);
    check({shs, roh, stc, etc}, img[3]);
    check({drs, grd}, img[4][5:0]);
    check(pat, {img[6], img[5]});
    check({tmo, brc}, img[7]);
  endtask
  // Counts whole cycles at one level; sampled on the falling clock edge.
  task automatic run_len(input logic lvl, output int len);
    int w;
    w = 0;
    len = 0;
    while (mon !== lvl && w < 30000) begin
      @(negedge clk);
      w++;
    end
    while (mon === lvl && len < 30000) begin
      @(negedge clk);
      len++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (rd_stb === 1'b1) begin
      if (exp_q.size() == 0) check(16'h0001, 16'h0000);
      else check(rd_byte, exp_q.pop_front());
    end
  end
  always @(negedge clk) for (int k = 0; k < 3; k++) if (dcp[k] === 1'b1) pul[k]++;
  initial begin
    #360000;
    error_cnt++;
    final_report();
  end
  initial begin
    defaults();
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check({amp, aw, sdo_oe}, 3'b100);
    check_ports();
    read_all();
    for (int r = 0; r < 2; r++) begin
      rssi <= 5'($random(seed));
      for (int i = 0; i < 14; i++) put(i, 8'($random(seed)) & (i == 0 ? 8'hEF : 8'hFF));
      wr(6'h00);
      check_ports();
      read_all();
    end
    repeat (5 + ($unsigned($random(seed)) % 11)) begin
      fw <= 1'b1;
      @(posedge clk);
      fw <= 1'b0;
      @(posedge clk);
      fcnt++;
    end
    read_all();
    cmd(`MODE_DIRECT, `DC_CLEAR_FALSE);
    fcnt = 0;
    read_all(6'h06);
    cmd(`MODE_DIRECT, `DC_CLEAR_WAKE);
    cmd(`MODE_DIRECT, `DC_RESET_RSSI);
    cmd(`MODE_DIRECT, `DC_TRIM_OSC);
    cmd(`MODE_DIRECT, 6'h05);
    cmd(2'h2, 6'h03);
    check(16'(pul[0] + 16 * pul[1] + 256 * pul[2]), 16'h0111);
    read_all();
    cmd(`MODE_DIRECT, `DC_PRESET);
    defaults();
    read_all();
    check_ports();
    put(0, 8'h22);
    wr(6'h00);
    for (int c = 0; c < 4; c++) begin
      put(4, {2'(c), 6'h10});
      wr(6'h04);
      @(negedge clk);
      run_len(1'b1, n);
      run_len(1'b0, n);
      check(16'(n), 16'(MS << c));
      run_len(1'b1, n);
      check(16'(n), 16'(MS));
      @(posedge clk);
    end
    put(0, 8'h02);
    wr(6'h00);
    put(8, 8'h01);
    wr(6'h08);
    sel_aw = 1'b1;
    @(negedge clk);
    run_len(1'b1, n);
    run_len(1'b0, n);
    check(16'(n), 16'(1000 * MS - AWP));
    run_len(1'b1, n);
    check(16'(n), 16'(AWP));
    final_report();
  end
endmodule // tb
`default_nettype wire
